// [rtl/rtc_digits_pkg.sv]
// constants for the bcd time and alarm register block
// assumes an apb3 master with 32-bit data and word-aligned addresses
package rtc_digits_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_YEAR = 8'h00;
    localparam logic [7:0] OFF_MMDD = 8'h04;
    localparam logic [7:0] OFF_WDHH = 8'h08;
    localparam logic [7:0] OFF_MMSS = 8'h0C;
    localparam logic [7:0] OFF_AL_MMDD = 8'h10;
    localparam logic [7:0] OFF_AL_WDHH = 8'h14;
    localparam logic [7:0] OFF_AL_MMSS = 8'h18;
    localparam logic [7:0] OFF_CTRL = 8'h1C;
    // implemented bits of each register
    localparam logic [15:0] YEAR_MASK = 16'h00FF;
    localparam logic [15:0] MMDD_MASK = 16'h1F3F;
    localparam logic [15:0] WDHH_MASK = 16'h073F;
    localparam logic [15:0] MMSS_MASK = 16'h7F7F;
    // control register bits
    localparam int CTRL_WREN_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    // digit field positions
    localparam int YEAR_TENS_LSB = 4;
    localparam int YEAR_ONES_LSB = 0;
    localparam int MONTH_TENS_BIT = 12;
    localparam int MONTH_ONES_LSB = 8;
    localparam int DAY_TENS_LSB = 4;
    localparam int DAY_ONES_LSB = 0;
    localparam int WEEKDAY_LSB = 8;
    localparam int HOUR_TENS_LSB = 4;
    localparam int HOUR_ONES_LSB = 0;
    localparam int MIN_TENS_LSB = 12;
    localparam int MIN_ONES_LSB = 8;
    localparam int SEC_TENS_LSB = 4;
    localparam int SEC_ONES_LSB = 0;
    // digit limits
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic [3:0] DIGIT_NINE = 4'h9;
    localparam logic [3:0] SIXTY_TENS_MAX = 4'h5;
    localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
    localparam logic [3:0] HOUR_ONES_LAST = 4'h3;
    localparam logic [2:0] WEEKDAY_MAX = 3'h6;
    localparam logic [4:0] MONTH_LAST = 5'h12;
    localparam logic [4:0] MONTH_FEB = 5'h02;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] DAY_FIRST = 8'h01;
    // values after reset
    localparam logic [15:0] DIGITS_RESET = 16'h0000;
    localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage : rtc_digits_pkg

// [rtl/rtc_bcd_time_alarm_regs.sv]
// bcd time and alarm value registers with an apb3 slave and a bcd time counter
// assumes second_tick is a one-cycle pulse from logic on pclk
//
// Functional notes
// - year tens digit in bits 7-4
// - year ones digit in bits 3-0
// - month tens single bit at 12
// - month ones digit in bits 11-8
// - day tens digit in bits 5-4
// - day ones digit in bits 3-0
// - weekday in bits 10-8, 0 to 6
// - hour tens digit in bits 5-4
// - hour ones digit in bits 3-0
// - minute tens digit in bits 14-12
// - minute ones digit in bits 11-8
// - second tens digit in bits 6-4
// - second ones digit in bits 3-0
// - unused bits read zero, ignore writes
// - year write only when write enable set
// - date and hour writes need write enable
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
module rtc_bcd_time_alarm_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic second_tick,
    output logic clock_write_enable,
    output logic [15:0] time_year_digits,
    output logic [15:0] time_month_day_digits,
    output logic [15:0] time_weekday_hour_digits,
    output logic [15:0] time_minute_second_digits,
    output logic [15:0] alarm_month_day_digits,
    output logic [15:0] alarm_weekday_hour_digits,
    output logic [15:0] alarm_minute_second_digits
);
    typedef struct packed {
        logic [15:0] year;
        logic [15:0] mmdd;
        logic [15:0] wdhh;
        logic [15:0] mmss;
        logic [15:0] al_mmdd;
        logic [15:0] al_wdhh;
        logic [15:0] al_mmss;
        logic wren;
        logic run;
        logic [31:0] rdata;
        logic err;
    } state_s;

    state_s c;
    state_s next_c;

    logic [7:0] addr;
    logic setup;
    logic wr;
    logic [15:0] wdata16;
    logic tick_go;
    logic leap;
    logic [7:0] last_day;
    logic [4:0] month;
    logic [7:0] day;
    logic cy_s1, cy_s10, cy_m1, cy_m10, cy_h, cy_d;
    logic [3:0] d_ones;
    logic [3:0] d_tens;

    assign addr = 8'(paddr);
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign wdata16 = pwdata[15:0];
    assign tick_go = second_tick && c.run;

    // zero wait states; read data is caught in the setup cycle so prdata is a flop
    assign pready = 1'b1;
    assign prdata = c.rdata;
    assign pslverr = c.err;
    assign clock_write_enable = c.wren;
    assign time_year_digits = c.year;
    assign time_month_day_digits = c.mmdd;
    assign time_weekday_hour_digits = c.wdhh;
    assign time_minute_second_digits = c.mmss;
    assign alarm_month_day_digits = c.al_mmdd;
    assign alarm_weekday_hour_digits = c.al_wdhh;
    assign alarm_minute_second_digits = c.al_mmss;

    function automatic logic [15:0] read_mux(input logic [7:0] a, input state_s s);
        case (a)
            rtc_digits_pkg::OFF_YEAR: read_mux = s.year;
            rtc_digits_pkg::OFF_MMDD: read_mux = s.mmdd;
            rtc_digits_pkg::OFF_WDHH: read_mux = s.wdhh;
            rtc_digits_pkg::OFF_MMSS: read_mux = s.mmss;
            rtc_digits_pkg::OFF_AL_MMDD: read_mux = s.al_mmdd;
            rtc_digits_pkg::OFF_AL_WDHH: read_mux = s.al_wdhh;
            rtc_digits_pkg::OFF_AL_MMSS: read_mux = s.al_mmss;
            rtc_digits_pkg::OFF_CTRL: read_mux = {14'h0000, s.run, s.wren};
            default: read_mux = 16'h0000;
        endcase
    endfunction : read_mux

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= rtc_digits_pkg::OFF_CTRL) && (a[1:0] == 2'b00);
    endfunction : mapped

    // leap year from two bcd digits: divisible by four
    always_comb begin
        d_ones = c.year[rtc_digits_pkg::YEAR_ONES_LSB +: 4];
        d_tens = c.year[rtc_digits_pkg::YEAR_TENS_LSB +: 4];
        if (d_tens[0]) begin
            leap = (d_ones == 4'h2) || (d_ones == 4'h6);
        end else begin
            leap = (d_ones == 4'h0) || (d_ones == 4'h4) || (d_ones == 4'h8);
        end
    end

    assign month = c.mmdd[rtc_digits_pkg::MONTH_ONES_LSB +: 5];
    assign day = {2'b00, c.mmdd[5:0]};

    always_comb begin
        case (month)
            rtc_digits_pkg::MONTH_FEB: begin
                last_day = leap ? rtc_digits_pkg::DAYS_29 : rtc_digits_pkg::DAYS_28;
            end
            5'h04, 5'h06, 5'h09, 5'h11: last_day = rtc_digits_pkg::DAYS_30;
            default: last_day = rtc_digits_pkg::DAYS_31;
        endcase
    end

    // carry chain; a digit only wraps when every lower digit wraps too
    assign cy_s1 = tick_go
        && (c.mmss[rtc_digits_pkg::SEC_ONES_LSB +: 4] == rtc_digits_pkg::DIGIT_NINE);
    assign cy_s10 = cy_s1
        && ({1'b0, c.mmss[rtc_digits_pkg::SEC_TENS_LSB +: 3]}
            == rtc_digits_pkg::SIXTY_TENS_MAX);
    assign cy_m1 = cy_s10
        && (c.mmss[rtc_digits_pkg::MIN_ONES_LSB +: 4] == rtc_digits_pkg::DIGIT_NINE);
    assign cy_m10 = cy_m1
        && ({1'b0, c.mmss[rtc_digits_pkg::MIN_TENS_LSB +: 3]}
            == rtc_digits_pkg::SIXTY_TENS_MAX);
    assign cy_h = cy_m10
        && ({2'b00, c.wdhh[rtc_digits_pkg::HOUR_TENS_LSB +: 2]}
            == rtc_digits_pkg::HOUR_TENS_MAX)
        && (c.wdhh[rtc_digits_pkg::HOUR_ONES_LSB +: 4] == rtc_digits_pkg::HOUR_ONES_LAST);
    assign cy_d = cy_h && (day == last_day);

    always_comb begin
        next_c = c;
        next_c.rdata = 32'h0000_0000;
        next_c.err = 1'b0;
        if (setup) begin
            next_c.err = !mapped(addr);
            if (!pwrite) begin
                next_c.rdata = {16'h0000, read_mux(addr, c)};
            end
        end
        // seconds and minutes
        if (tick_go) begin
            next_c.mmss[rtc_digits_pkg::SEC_ONES_LSB +: 4] = cy_s1 ?
                rtc_digits_pkg::DIGIT_ZERO :
                c.mmss[rtc_digits_pkg::SEC_ONES_LSB +: 4] + 4'h1;
        end
        if (cy_s1) begin
            next_c.mmss[rtc_digits_pkg::SEC_TENS_LSB +: 3] = cy_s10 ? 3'h0 :
                c.mmss[rtc_digits_pkg::SEC_TENS_LSB +: 3] + 3'h1;
        end
        if (cy_s10) begin
            next_c.mmss[rtc_digits_pkg::MIN_ONES_LSB +: 4] = cy_m1 ?
                rtc_digits_pkg::DIGIT_ZERO :
                c.mmss[rtc_digits_pkg::MIN_ONES_LSB +: 4] + 4'h1;
        end
        if (cy_m1) begin
            next_c.mmss[rtc_digits_pkg::MIN_TENS_LSB +: 3] = cy_m10 ? 3'h0 :
                c.mmss[rtc_digits_pkg::MIN_TENS_LSB +: 3] + 3'h1;
        end
        // hours: ones wrap at 9, or at 3 when the tens digit is 2
        if (cy_m10) begin
            if (cy_h) begin
                next_c.wdhh[5:0] = 6'h00;
            end else if (c.wdhh[rtc_digits_pkg::HOUR_ONES_LSB +: 4]
                         == rtc_digits_pkg::DIGIT_NINE) begin
                next_c.wdhh[rtc_digits_pkg::HOUR_ONES_LSB +: 4] = rtc_digits_pkg::DIGIT_ZERO;
                next_c.wdhh[rtc_digits_pkg::HOUR_TENS_LSB +: 2] =
                    c.wdhh[rtc_digits_pkg::HOUR_TENS_LSB +: 2] + 2'h1;
            end else begin
                next_c.wdhh[rtc_digits_pkg::HOUR_ONES_LSB +: 4] =
                    c.wdhh[rtc_digits_pkg::HOUR_ONES_LSB +: 4] + 4'h1;
            end
        end
        // day of week and day of month
        if (cy_h) begin
            next_c.wdhh[rtc_digits_pkg::WEEKDAY_LSB +: 3] =
                (c.wdhh[rtc_digits_pkg::WEEKDAY_LSB +: 3] == rtc_digits_pkg::WEEKDAY_MAX) ?
                3'h0 : c.wdhh[rtc_digits_pkg::WEEKDAY_LSB +: 3] + 3'h1;
            if (cy_d) begin
                next_c.mmdd[5:0] = 6'(rtc_digits_pkg::DAY_FIRST);
            end else if (c.mmdd[rtc_digits_pkg::DAY_ONES_LSB +: 4]
                         == rtc_digits_pkg::DIGIT_NINE) begin
                next_c.mmdd[rtc_digits_pkg::DAY_ONES_LSB +: 4] = rtc_digits_pkg::DIGIT_ZERO;
                next_c.mmdd[rtc_digits_pkg::DAY_TENS_LSB +: 2] =
                    c.mmdd[rtc_digits_pkg::DAY_TENS_LSB +: 2] + 2'h1;
            end else begin
                next_c.mmdd[rtc_digits_pkg::DAY_ONES_LSB +: 4] =
                    c.mmdd[rtc_digits_pkg::DAY_ONES_LSB +: 4] + 4'h1;
            end
        end
        // month and year
        if (cy_d) begin
            if (month == rtc_digits_pkg::MONTH_LAST) begin
                next_c.mmdd[12:8] = 5'(rtc_digits_pkg::DIGIT_ONE);
                if (c.year[rtc_digits_pkg::YEAR_ONES_LSB +: 4] == rtc_digits_pkg::DIGIT_NINE) begin
                    next_c.year[rtc_digits_pkg::YEAR_ONES_LSB +: 4] = rtc_digits_pkg::DIGIT_ZERO;
                    next_c.year[rtc_digits_pkg::YEAR_TENS_LSB +: 4] =
                        (c.year[rtc_digits_pkg::YEAR_TENS_LSB +: 4] == rtc_digits_pkg::DIGIT_NINE)
                        ? rtc_digits_pkg::DIGIT_ZERO
                        : c.year[rtc_digits_pkg::YEAR_TENS_LSB +: 4] + 4'h1;
                end else begin
                    next_c.year[rtc_digits_pkg::YEAR_ONES_LSB +: 4] =
                        c.year[rtc_digits_pkg::YEAR_ONES_LSB +: 4] + 4'h1;
                end
            end else if (c.mmdd[rtc_digits_pkg::MONTH_ONES_LSB +: 4]
                         == rtc_digits_pkg::DIGIT_NINE) begin
                next_c.mmdd[12:8] = 5'h10;
            end else begin
                next_c.mmdd[rtc_digits_pkg::MONTH_ONES_LSB +: 4] =
                    c.mmdd[rtc_digits_pkg::MONTH_ONES_LSB +: 4] + 4'h1;
            end
        end
        // a software write in the same cycle as a carry wins for that register
        if (wr) begin
            case (addr)
                rtc_digits_pkg::OFF_YEAR: begin
                    if (c.wren) begin
                        next_c.year = wdata16 & rtc_digits_pkg::YEAR_MASK;
                    end
                end
                rtc_digits_pkg::OFF_MMDD: begin
                    if (c.wren) begin
                        next_c.mmdd = wdata16 & rtc_digits_pkg::MMDD_MASK;
                    end
                end
                rtc_digits_pkg::OFF_WDHH: begin
                    if (c.wren) begin
                        next_c.wdhh = wdata16 & rtc_digits_pkg::WDHH_MASK;
                    end
                end
                rtc_digits_pkg::OFF_MMSS: begin
                    next_c.mmss = wdata16 & rtc_digits_pkg::MMSS_MASK;
                end
                rtc_digits_pkg::OFF_AL_MMDD: begin
                    if (c.wren) begin
                        next_c.al_mmdd = wdata16 & rtc_digits_pkg::MMDD_MASK;
                    end
                end
                rtc_digits_pkg::OFF_AL_WDHH: begin
                    if (c.wren) begin
                        next_c.al_wdhh = wdata16 & rtc_digits_pkg::WDHH_MASK;
                    end
                end
                rtc_digits_pkg::OFF_AL_MMSS: begin
                    next_c.al_mmss = wdata16 & rtc_digits_pkg::MMSS_MASK;
                end
                rtc_digits_pkg::OFF_CTRL: begin
                    next_c.wren = pwdata[rtc_digits_pkg::CTRL_WREN_BIT];
                    next_c.run = pwdata[rtc_digits_pkg::CTRL_RUN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // digits clear to zero but software must still load them before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c <= '0;
            c.year <= rtc_digits_pkg::DIGITS_RESET;
            c.mmdd <= rtc_digits_pkg::DIGITS_RESET;
            c.wdhh <= rtc_digits_pkg::DIGITS_RESET;
            c.mmss <= rtc_digits_pkg::DIGITS_RESET;
            c.wren <= rtc_digits_pkg::CTRL_RESET[rtc_digits_pkg::CTRL_WREN_BIT];
            c.run <= rtc_digits_pkg::CTRL_RESET[rtc_digits_pkg::CTRL_RUN_BIT];
        end else begin
            c <= next_c;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_year, wr_mmdd, wr_wdhh, wr_mmss, wr_almd;
    assign wr_year = wr && (addr == rtc_digits_pkg::OFF_YEAR);
    assign wr_mmdd = wr && (addr == rtc_digits_pkg::OFF_MMDD);
    assign wr_wdhh = wr && (addr == rtc_digits_pkg::OFF_WDHH);
    assign wr_mmss = wr && (addr == rtc_digits_pkg::OFF_MMSS);
    assign wr_almd = wr && (addr == rtc_digits_pkg::OFF_AL_MMDD);

    property p_year_locked;
        wr_year && !c.wren && !cy_d |=> $stable(c.year);
    endproperty
    a_year_locked: assert property (p_year_locked)
        else $error("year changed by a write while locked");

    property p_year_written;
        wr_year && c.wren |=> c.year == (rtc_digits_pkg::YEAR_MASK & $past(wdata16));
    endproperty
    a_year_written: assert property (p_year_written)
        else $error("accepted year write not stored");

    property p_alarm_locked;
        wr_almd && !c.wren |=> $stable(c.al_mmdd) [*2];
    endproperty
    a_alarm_locked: assert property (p_alarm_locked)
        else $error("alarm date changed while locked");

    property p_month_written;
        wr_mmdd && c.wren |=> c.mmdd == (rtc_digits_pkg::MMDD_MASK & $past(wdata16));
    endproperty
    a_month_written: assert property (p_month_written)
        else $error("accepted month-day write not stored");

    property p_read_upper_zero;
        setup && !pwrite && addr == rtc_digits_pkg::OFF_YEAR
            |=> penable && prdata[31:8] == 24'h00_0000;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero)
        else $error("unused year bits read nonzero");

    property p_mmss_written;
        wr_mmss |=> c.mmss == (rtc_digits_pkg::MMSS_MASK & $past(wdata16))
            && !c.mmss[15] && !c.mmss[7];
    endproperty
    a_mmss_written: assert property (p_mmss_written)
        else $error("minute-second write not stored");

    property p_second_wrap;
        tick_go && !wr_mmss && c.mmss[7:0] == 8'h59
            |=> c.mmss[7:0] == 8'h00
            && c.mmss[11:8] != $past(c.mmss[11:8]);
    endproperty
    a_second_wrap: assert property (p_second_wrap)
        else $error("seconds did not carry into minutes");

    property p_hour_wrap;
        tick_go && !wr_mmss && !wr_wdhh && c.mmss == 16'h5959
            && c.wdhh[5:0] == 6'h23 && c.wdhh[10:8] == 3'h6
            |=> c.wdhh[10:0] == 11'h000;
    endproperty
    a_hour_wrap: assert property (p_hour_wrap)
        else $error("hour or weekday failed to wrap");

    property p_idle_stable;
        !tick_go && !wr ##1 !tick_go && !wr |=> $stable(c.mmss) && $stable(c.year);
    endproperty
    a_idle_stable: assert property (p_idle_stable)
        else $error("time moved with no tick");

    c_year_write: cover property (wr_year && c.wren ##1 c.year == rtc_digits_pkg::YEAR_MASK);
    c_write_blocked: cover property (wr_mmdd && !c.wren);
    c_hour_roll: cover property (cy_h);
    c_year_roll: cover property (cy_d && month == rtc_digits_pkg::MONTH_LAST);
endmodule : rtc_bcd_time_alarm_regs

// [verification/rtc_bcd_time_alarm_regs_tb.sv]
// self-checking bench for the bcd time and alarm register block
// assumes the design answers apb with its own pready and drives digits from flops
`timescale 1ns/10ps
module rtc_bcd_time_alarm_regs_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic second_tick = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic clock_write_enable;
    logic [15:0] port_val [0:6];
    int n_fail = 0;
    int checks = 0;
    logic [15:0] lfsr = 16'hEFC5;
    logic [15:0] mdl [0:6];
    logic wren = 1'b0;
    logic [1:0] ctrl_mdl = 2'h0;
    logic [31:0] rd;
    logic err;
    localparam logic [15:0] MASKS [0:6] = '{rtc_digits_pkg::YEAR_MASK,
        rtc_digits_pkg::MMDD_MASK, rtc_digits_pkg::WDHH_MASK, rtc_digits_pkg::MMSS_MASK,
        rtc_digits_pkg::MMDD_MASK, rtc_digits_pkg::WDHH_MASK, rtc_digits_pkg::MMSS_MASK};
    // minute-second registers stay writable with the enable clear
    localparam logic GATED [0:6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    // start year, date, weekday-hour, min-sec, then the same four after one tick
    localparam logic [15:0] TCASE [0:2][0:7] = '{
        '{16'h0099, 16'h1231, 16'h0623, 16'h5959, 16'h0000, 16'h0101, 16'h0000, 16'h0000},
        '{16'h0024, 16'h0228, 16'h0323, 16'h5959, 16'h0024, 16'h0229, 16'h0400, 16'h0000},
        '{16'h0023, 16'h0228, 16'h0209, 16'h1959, 16'h0023, 16'h0228, 16'h0209, 16'h2000}};

    rtc_bcd_time_alarm_regs u_rtc_bcd_time_alarm_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .second_tick(second_tick),
        .clock_write_enable(clock_write_enable),
        .time_year_digits(port_val[0]),
        .time_month_day_digits(port_val[1]),
        .time_weekday_hour_digits(port_val[2]),
        .time_minute_second_digits(port_val[3]),
        .alarm_month_day_digits(port_val[4]),
        .alarm_weekday_hour_digits(port_val[5]),
        .alarm_minute_second_digits(port_val[6])
    );

    always #10 pclk = ~pclk;

    function automatic logic [15:0] lfsr_step();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : lfsr_step

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_port(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: port %h expected %h", $time, got, exp);
        end
    endtask : cmp_port

    task automatic cmp_err(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: error %h expected %h", $time, got, exp);
        end
    endtask : cmp_err

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input int i, input logic [31:0] wd);
        apb(1'b1, 8'(i * 4), wd);
        if (!(GATED[i] && !wren))
            mdl[i] = wd[15:0] & MASKS[i];
        cmp_err(err, 1'b0);
    endtask : wr_reg

    task automatic wr_ctrl(input logic [1:0] v);
        apb(1'b1, rtc_digits_pkg::OFF_CTRL, {30'h0, v});
        wren = v[0];
        ctrl_mdl = v;
    endtask : wr_ctrl

    // one-cycle second pulse, seen by the design at the second edge
    task automatic pulse_tick();
        @(posedge pclk);
        second_tick <= 1'b1;
        @(posedge pclk);
        second_tick <= 1'b0;
    endtask : pulse_tick

    task automatic check_all(input string name);
        @(negedge pclk);
        cmp_err(clock_write_enable, wren);
        for (int i = 0; i < 7; i++)
            cmp_port(port_val[i], mdl[i]);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            cmp_data(rd, {16'h0000, mdl[i]});
            cmp_err(err, 1'b0);
        end
        apb(1'b0, rtc_digits_pkg::OFF_CTRL, 32'h0000_0000);
        cmp_data(rd, {30'h0, ctrl_mdl});
        $display("test %s done, checks %0d, n_fail %0d", name, checks, n_fail);
    endtask : check_all

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 7; i++)
            mdl[i] = 16'h0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // digits are loaded before use, so reset contents only need to read back
        check_all("reset");
        // enable clear: only the minute-second registers take a write
        wr_ctrl(2'h0);
        for (int i = 0; i < 7; i++)
            wr_reg(i, {lfsr_step(), lfsr_step()});
        check_all("write gated");
        // enable set: first round all ones to expose every unused bit
        wr_ctrl(2'h1);
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 7; i++)
                wr_reg(i, (r == 0) ? 32'hFFFF_FFFF : {lfsr_step(), lfsr_step()});
            check_all("write open");
        end
        // unmapped and unaligned places answer with an error and change nothing
        foreach (MASKS[k]) begin
            apb(k[0], (k < 3) ? 8'(8'h20 + 4 * k) : 8'(4 * k + 1), 32'hFFFF_FFFF);
            cmp_err(err, 1'b1);
            cmp_data(rd, 32'h0000_0000);
        end
        check_all("unmapped");
        // one tick at the carry limits of every field
        for (int c = 0; c < 3; c++) begin
            wr_ctrl(2'h1);
            for (int i = 0; i < 4; i++)
                wr_reg(i, {16'h0000, TCASE[c][i]});
            // a tick with the clock stopped must leave every digit alone
            pulse_tick();
            wr_ctrl(2'h3);
            pulse_tick();
            for (int i = 0; i < 4; i++)
                mdl[i] = TCASE[c][i + 4];
            wr_ctrl(2'h1);
            check_all("tick carry");
        end
        close_out();
    end
endmodule : rtc_bcd_time_alarm_regs_tb
